// ==== src/pma_defines.vh ====
/*
 * constants for the phy management access block: register offsets, field
 * positions, reset values and serial timing.
 * assumes it is included by its bare name from the design files.
 */
`ifndef PMA_DEFINES_VH
`define PMA_DEFINES_VH

// ==========================================================
// register byte offsets
`define PMA_OFS_ACCESS      8'h00
`define PMA_OFS_LINK_MODE   8'h04
`define PMA_OFS_MODE1       8'h08
`define PMA_OFS_INT_MASK    8'h0c
`define PMA_OFS_INT_STATUS  8'h10
`define PMA_OFS_POLL_ADDR   8'h14

// ==========================================================
// access register fields
`define PMA_DATA_LSB        0
`define PMA_DATA_MSB        15
`define PMA_IDX_LSB         16
`define PMA_IDX_MSB         20
`define PMA_ADDR_LSB        21
`define PMA_ADDR_MSB        25
`define PMA_CMD_BIT         26
`define PMA_BUSY_BIT        31
`define PMA_CMD_READ        1'b0
`define PMA_CMD_WRITE       1'b1

// ==========================================================
// other fields and reset values
`define PMA_MODE1_POLL_EN   0
`define PMA_MODE1_SOFT_RST  1
`define PMA_MASK_STS_CHG    0
`define PMA_LINK_MODE_RST   3'h0
`define PMA_POLL_ADDR_RST   5'h00
`define PMA_STATUS_IDX      5'h01
`define PMA_SOFT_RST_CYC    8'h10

// ==========================================================
// serial timing
`define PMA_MDC_MAX_NS      400
`define PMA_CLK_NS          10
`define PMA_MDC_HALF_CYC    ((`PMA_MDC_MAX_NS + 2 * `PMA_CLK_NS - 1) / (2 * `PMA_CLK_NS))
`define PMA_POLL_GAP_CYC    20000

`endif

// ==== src/pma_serial.v ====
/*
 * standard management frame engine: one read or write per start pulse.
 * assumes the phy data pin is two-way and resolved outside; mdio_in comes
 * straight from the pin and is synchronised here.
 */
`timescale 1ns/1ps
`include "pma_defines.vh"

module pma_serial #(
	parameter HALF_CYC = `PMA_MDC_HALF_CYC
) (
	input  wire        aclk,
	input  wire        rst_n,
	input  wire        start,
	input  wire        is_write,
	input  wire [4:0]  phy_addr,
	input  wire [4:0]  reg_idx,
	input  wire [15:0] wdata,
	output reg         busy,
	output reg         done,
	output reg  [15:0] rdata,
	output reg         mdc,
	output reg         mdio_out,
	output reg         mdio_oe,
	input  wire        mdio_in
);

	reg  [63:0] shreg;
	reg  [6:0]  bitn;
	reg  [15:0] div;
	reg         wr;
	reg         sync1;
	reg         sync2;
	wire        tick = (div == HALF_CYC[15:0] - 16'h0001);

	// ==========================================================
	// pin synchroniser
	always @(posedge aclk)
	begin
		sync1 <= mdio_in;
		sync2 <= sync1;
	end

	// ==========================================================
	// frame: 32 preamble, start, op, addr, reg, turnaround, 16 data
	always @(posedge aclk)
	begin
		if (!rst_n)
		begin
			busy     <= 1'b0;
			done     <= 1'b0;
			rdata    <= 16'h0000;
			mdc      <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe  <= 1'b0;
			shreg    <= 64'h0;
			bitn     <= 7'h00;
			div      <= 16'h0000;
			wr       <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!busy)
			begin
				mdc <= 1'b0;
				div <= 16'h0000;
				if (start)
				begin
					busy  <= 1'b1;
					wr    <= is_write;
					bitn  <= 7'h00;
					shreg <= {32'hffffffff, 2'b01, (is_write ? 2'b01 : 2'b10),
						phy_addr, reg_idx, 2'b10, wdata};
				end
			end
			else if (!tick)
				div <= div + 16'h0001;
			else
			begin
				div <= 16'h0000;
				mdc <= ~mdc;
				if (!mdc)
				begin
					// data changes on the falling edge, rising samples
					rdata <= (bitn > 7'd48) ? {rdata[14:0], sync2} : rdata;
				end
				else
				begin
					mdio_out <= shreg[63];
					mdio_oe  <= wr || (bitn < 7'd46);
					shreg    <= {shreg[62:0], 1'b1};
					bitn     <= bitn + 7'h01;
					if (bitn == 7'd64)
					begin
						busy    <= 1'b0;
						done    <= 1'b1;
						mdio_oe <= 1'b0;
					end
				end
			end
		end
	end

endmodule

// ==== src/pma_top.v ====
/*
 * phy management access with axi4-lite registers, background status poll
 * and a link mode output for the mac datapath.
 * assumes a single 100 mhz clock and a bus reset driven onto aresetn.
 */
// Functional notes
// - one access register reaches every phy register
// - vendor registers reached with no special handling
// - busy set during transfer, cleared on completion
// - read result left in data field
// - write data sent with starting write
// - link mode steers mac speed and duplex
// - poll status, interrupt when value changes
// - poll only with enable and mask set
// - bus reset returns everything to initial state
// - host access during soft reset gets retried
`timescale 1ns/1ps
`include "pma_defines.vh"

module pma_top #(
	parameter POLL_GAP = `PMA_POLL_GAP_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         phy_status_irq,
	output reg  [2:0]  link_mode,
	output reg         soft_reset_active,
	output wire        mdc,
	output wire        mdio_out,
	output wire        mdio_oe,
	input  wire        mdio_in
);

	reg  [4:0]  phy_reg_index;
	reg         phy_access_cmd;
	reg  [4:0]  phy_addr_field;
	reg  [15:0] phy_data_field;
	reg         phy_access_busy;
	reg         phy_status_poll_enable;
	reg         phy_status_change_mask;
	reg  [4:0]  poll_addr;
	reg  [15:0] last_status;
	reg         status_valid;
	reg  [31:0] poll_cnt;
	reg         poll_active;
	reg  [7:0]  srst_cnt;
	reg         aw_held;
	reg  [7:0]  aw_addr;
	reg         w_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         eng_start;
	reg         eng_write;
	reg  [4:0]  eng_addr;
	reg  [4:0]  eng_idx;
	wire        eng_busy;
	wire        eng_done;
	wire [15:0] eng_rdata;
	wire        rst_n = aresetn && !soft_reset_active;
	wire        poll_on = phy_status_poll_enable && phy_status_change_mask;
	wire        do_write = aw_held && w_held && !s_axi_bvalid;

	function known;
		input [7:0] a;
		begin
			known = (a == `PMA_OFS_ACCESS) || (a == `PMA_OFS_LINK_MODE) ||
				(a == `PMA_OFS_MODE1) || (a == `PMA_OFS_INT_MASK) ||
				(a == `PMA_OFS_INT_STATUS) || (a == `PMA_OFS_POLL_ADDR);
		end
	endfunction

	// ==========================================================
	// axi handshake; channels stall during soft reset so hosts retry
	assign s_axi_awready = !aw_held && !soft_reset_active;
	assign s_axi_wready  = !w_held && !soft_reset_active;
	assign s_axi_arready = !s_axi_rvalid && !soft_reset_active;

	pma_serial u_serial (
		.aclk     (aclk),
		.rst_n    (rst_n),
		.start    (eng_start),
		.is_write (eng_write),
		.phy_addr (eng_addr),
		.reg_idx  (eng_idx),
		.wdata    (phy_data_field),
		.busy     (eng_busy),
		.done     (eng_done),
		.rdata    (eng_rdata),
		.mdc      (mdc),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.mdio_in  (mdio_in)
	);

	// ==========================================================
	// soft reset counter only yields to the bus reset
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			srst_cnt          <= 8'h00;
			soft_reset_active <= 1'b0;
		end
		else if (do_write && aw_addr == `PMA_OFS_MODE1 && w_strb[0] && w_data[`PMA_MODE1_SOFT_RST])
		begin
			srst_cnt          <= `PMA_SOFT_RST_CYC;
			soft_reset_active <= 1'b1;
		end
		else if (srst_cnt != 8'h00)
			srst_cnt <= srst_cnt - 8'h01;
		else
			soft_reset_active <= 1'b0;
	end

	// ==========================================================
	// registers, access sequencing and status poll
	always @(posedge aclk)
	begin
		if (!rst_n)
		begin
			phy_reg_index          <= 5'h00;
			phy_access_cmd         <= `PMA_CMD_READ;
			phy_addr_field         <= 5'h00;
			phy_data_field         <= 16'h0000;
			phy_access_busy        <= 1'b0;
			phy_status_poll_enable <= 1'b0;
			phy_status_change_mask <= 1'b0;
			poll_addr              <= `PMA_POLL_ADDR_RST;
			link_mode              <= `PMA_LINK_MODE_RST;
			last_status            <= 16'h0000;
			status_valid           <= 1'b0;
			poll_cnt               <= 32'h0;
			poll_active            <= 1'b0;
			phy_status_irq         <= 1'b0;
			aw_held                <= 1'b0;
			aw_addr                <= 8'h00;
			w_held                 <= 1'b0;
			w_data                 <= 32'h0;
			w_strb                 <= 4'h0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= 2'b00;
			s_axi_rvalid           <= 1'b0;
			s_axi_rresp            <= 2'b00;
			s_axi_rdata            <= 32'h0;
			eng_start              <= 1'b0;
			eng_write              <= 1'b0;
			eng_addr               <= 5'h00;
			eng_idx                <= 5'h00;
		end
		else
		begin
			eng_start <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known(aw_addr) ? 2'b00 : 2'b10;
				case (aw_addr)
				`PMA_OFS_ACCESS:
					// one word starts any index, standard or vendor
					if (!phy_access_busy && (&w_strb))
					begin
						phy_data_field  <= w_data[`PMA_DATA_MSB:`PMA_DATA_LSB];
						phy_reg_index   <= w_data[`PMA_IDX_MSB:`PMA_IDX_LSB];
						phy_addr_field  <= w_data[`PMA_ADDR_MSB:`PMA_ADDR_LSB];
						phy_access_cmd  <= w_data[`PMA_CMD_BIT];
						phy_access_busy <= 1'b1;
					end
				`PMA_OFS_LINK_MODE:
					if (w_strb[0])
						link_mode <= w_data[2:0];
				`PMA_OFS_MODE1:
					if (w_strb[0])
						phy_status_poll_enable <= w_data[`PMA_MODE1_POLL_EN];
				`PMA_OFS_INT_MASK:
					if (w_strb[0])
						phy_status_change_mask <= w_data[`PMA_MASK_STS_CHG];
				`PMA_OFS_POLL_ADDR:
					if (w_strb[0])
						poll_addr <= w_data[4:0];
				default:
					s_axi_bresp <= 2'b10;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= known(s_axi_araddr) ? 2'b00 : 2'b10;
				case (s_axi_araddr)
				`PMA_OFS_ACCESS:
					s_axi_rdata <= {phy_access_busy, 4'h0, phy_access_cmd, phy_addr_field,
						phy_reg_index, phy_data_field};
				`PMA_OFS_LINK_MODE:
					s_axi_rdata <= {29'h0, link_mode};
				`PMA_OFS_MODE1:
					s_axi_rdata <= {31'h0, phy_status_poll_enable};
				`PMA_OFS_INT_MASK:
					s_axi_rdata <= {31'h0, phy_status_change_mask};
				`PMA_OFS_INT_STATUS:
					s_axi_rdata <= {15'h0, phy_status_irq, last_status};
				`PMA_OFS_POLL_ADDR:
					s_axi_rdata <= {27'h0, poll_addr};
				default:
					s_axi_rdata <= 32'h0;
				endcase
				// reading status acknowledges the change, unless a new one lands now
				if (s_axi_araddr == `PMA_OFS_INT_STATUS)
					phy_status_irq <= 1'b0;
			end

			// host transfer has priority; poll only starts while idle
			if (phy_access_busy && !eng_busy && !eng_start && !poll_active)
			begin
				if (eng_done)
				begin
					phy_access_busy <= 1'b0;
					if (phy_access_cmd == `PMA_CMD_READ)
						phy_data_field <= eng_rdata;
				end
				else
				begin
					eng_start <= 1'b1;
					eng_write <= phy_access_cmd;
					eng_addr  <= phy_addr_field;
					eng_idx   <= phy_reg_index;
				end
			end
			else if (poll_active && eng_done)
			begin
				poll_active  <= 1'b0;
				status_valid <= 1'b1;
				last_status  <= eng_rdata;
				if (status_valid && eng_rdata != last_status)
					phy_status_irq <= 1'b1;
			end
			else if (!phy_access_busy && !eng_busy && !eng_start && !poll_active)
			begin
				if (!poll_on)
					poll_cnt <= 32'h0;
				else if (poll_cnt < POLL_GAP - 1)
					poll_cnt <= poll_cnt + 32'h1;
				else
				begin
					poll_cnt    <= 32'h0;
					poll_active <= 1'b1;
					eng_start   <= 1'b1;
					eng_write   <= `PMA_CMD_READ;
					eng_addr    <= poll_addr;
					eng_idx     <= `PMA_STATUS_IDX;
				end
			end
		end
	end

endmodule

// ==== bench/pma_phy_model.sv ====
/* partner model: one phy answering management frames at PHY_ADDR.
   assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
// ==========
// phy model
module pma_phy_model #(
	parameter PHY_ADDR = 5'h03
) (
	input  wire mdc,
	input  wire mdio_in,
	input  wire link_up,
	output reg  phy_oe,
	output reg  phy_out
);
	reg  [15:0] mem [0:31];
	reg  [15:0] sr;
	reg  [13:0] hdr;
	reg  [5:0]  n;
	integer     i;
	wire [15:0] sts = 16'h7909 | {13'h0000, link_up, 2'h0};
	wire [15:0] q = (hdr[4:0] == 5'h01) ? sts : mem[hdr[4:0]];
	wire        me = hdr[9:5] == PHY_ADDR;
	initial
	begin
		for (i = 0; i < 32; i = i + 1)
			mem[i] = 16'h3c00 | i[4:0];
		n = 6'h00;
		hdr = 14'h0000;
		phy_oe = 1'b0;
		phy_out = 1'b0;
	end
	// a frame begins at the first zero after the preamble
	always @(posedge mdc)
	begin
		sr <= {sr[14:0], mdio_in};
		if (n == 6'h00)
			n <= {5'h00, !mdio_in};
		else
			n <= (n == 6'h1f) ? 6'h00 : n + 6'h01;
		if (n == 6'h0d)
			hdr <= {sr[12:0], mdio_in};
		if (n == 6'h1f && me && hdr[11:10] == 2'h1)
			mem[hdr[4:0]] <= {sr[14:0], mdio_in};
	end
	// drive on the fall so the line is settled at the next rise
	always @(negedge mdc)
	begin
		phy_oe <= me && hdr[11:10] == 2'h2 && n >= 6'h0f;
		phy_out <= n[4] & q[~n[3:0]];
	end
endmodule

// ==== bench/pma_top_assertions.sv ====
/* checker on the pma_top ports, bound into every pma_top.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
// ==========
// checker
module pma_chk (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_arready,
	input wire        s_axi_arvalid,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        phy_status_irq,
	input wire [2:0]  link_mode,
	input wire        soft_reset_active,
	input wire        mdc,
	input wire        mdio_oe
);
	reg [7:0] since_mdc;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// an interrupt may only follow a finished poll frame
	always @(posedge aclk)
		if (!aresetn || $rose(mdc))
			since_mdc <= 8'h00;
		else if (since_mdc != 8'hff)
			since_mdc <= since_mdc + 8'h01;
	rst_idle_a:
		assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
			&& !phy_status_irq && !mdc && !mdio_oe && link_mode == 3'h0) else $error("outputs busy in reset");
	soft_retry_a:
		assert property (soft_reset_active |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
			else $error("bus taken during soft reset");
	link_read_a:
		assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
			|=> s_axi_rvalid && s_axi_rdata[2:0] == link_mode) else $error("link mode read mismatch");
	bad_addr_a:
		assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
			|=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read answer");
	rd_stall_a:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
	b_once_a:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answered twice");
	mdc_half_a:
		assert property ($rose(mdc) |=> $stable(mdc) [*8]) else $error("management clock too fast");
	irq_cause_a:
		assert property ($rose(phy_status_irq) |-> since_mdc < 8'hc8) else $error("interrupt without poll");
endmodule
bind pma_top pma_chk i_pma_chk (.*);

// ==== bench/pma_top_tb.sv ====
/* bench for the phy management access block with an axi4-lite master and a phy model.
   assumes the design answers within the watchdog span. */
`timescale 1ns/1ps
// ==========
// bench top
module pma_top_tb;
	localparam [4:0] PA = 5'h03;
	reg         aclk, aresetn, link_up;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata;
	reg  [3:0]  s_axi_wstrb;
	reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0]  link_mode;
	wire        phy_status_irq, soft_reset_active, mdc, mdio_out, mdio_oe, phy_oe, phy_out;
	wire        mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
	integer     err_count, total_checks, n;
	reg  [31:0] d;
	reg  [1:0]  r;
	reg  [15:0] q;

	pma_top #(.POLL_GAP(50)) i_pma_top (.*);
	pma_phy_model #(.PHY_ADDR(PA)) i_pma_phy_model (.*);

	// ==========
	// tasks
	task chk(input [33:0] g, input [33:0] e);
	begin
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	// nob skips the answer, which a soft reset swallows
	task wr(input [7:0] a, input [31:0] v, input nob, output [1:0] rs);
		reg aw, w;
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw = 0;
		w = 0;
		rs = 2'h0;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (!nob)
		begin
			do @(posedge aclk); while (!s_axi_bvalid);
			rs = s_axi_bresp;
		end
	end
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
	end
	endtask
	task idle(output [15:0] v);
	begin
		do rd(8'h00, d, r); while (d[31]);
		v = d[15:0];
	end
	endtask
	task phy(input [4:0] pa, input [4:0] ix, input we, input [15:0] wd, output [15:0] v);
	begin
		wr(8'h00, {5'h00, we, pa, ix, wd}, 0, r);
		rd(8'h00, d, r);
		chk(d[31], 1'h1);
		idle(v);
	end
	endtask
	task stop_test;
	begin
		$display("errors %0d checks %0d", err_count, total_checks);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	// ==========
	// stimulus
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	initial
	begin
		#900000;
		err_count++;
		stop_test;
	end
	initial
	begin
		{aresetn, link_up, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, err_count, total_checks} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h04, d, r);
		chk(d, 0);
		rd(8'h18, d, r);
		chk({r, d}, {2'h2, 32'h0});
		wr(8'h1c, 32'h1, 0, r);
		chk(r, 2'h2);
		phy(PA, 5'h00, 0, 0, q);
		chk(q, 16'h3c00);
		phy(PA, 5'h01, 0, 0, q);
		chk(q, 16'h7909);
		phy(PA, 5'h0f, 0, 0, q);
		chk(q, 16'h3c0f);
		phy(5'h07, 5'h01, 0, 0, q);
		chk(q, 16'hffff);
		phy(PA, 5'h00, 1, 16'h1200, q);
		wr(8'h00, {6'h01, PA, 5'h1a, 16'ha5c3}, 0, r);
		wr(8'h00, {6'h01, PA, 5'h1a, 16'h0f0f}, 0, r);
		idle(q);
		phy(PA, 5'h1a, 0, 0, q);
		chk(q, 16'ha5c3);
		wr(8'h04, 32'h5, 0, r);
		@(posedge aclk);
		chk(link_mode, 3'h5);
		wr(8'h14, PA, 0, r);
		wr(8'h08, 32'h1, 0, r);
		link_up <= 1'b1;
		repeat (3000) @(posedge aclk);
		// status changes here would interrupt if polling ran on the enable alone
		link_up <= 1'b0;
		repeat (3000) @(posedge aclk);
		chk(phy_status_irq, 0);
		link_up <= 1'b1;
		wr(8'h0c, 32'h1, 0, r);
		repeat (6000) @(posedge aclk);
		chk(phy_status_irq, 0);
		phy(PA, 5'h00, 0, 0, q);
		chk(q, 16'h1200);
		link_up <= 1'b0;
		n = 0;
		while (!phy_status_irq && n < 8000)
		begin
			@(posedge aclk);
			n++;
		end
		chk(phy_status_irq, 1);
		rd(8'h10, d, r);
		chk(d[16:0], {1'h1, 16'h7909});
		@(posedge aclk);
		chk(phy_status_irq, 0);
		wr(8'h08, 32'h0, 0, r);
		// let a poll frame already under way finish before the soft reset cuts the line
		repeat (3000) @(posedge aclk);
		wr(8'h08, 32'h2, 1, r);
		do @(posedge aclk); while (!soft_reset_active);
		rd(8'h04, d, r);
		chk(d, 0);
		wr(8'h04, 32'h6, 0, r);
		chk(link_mode, 3'h6);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(link_mode, 3'h0);
		aresetn <= 1'b1;
		stop_test;
	end
endmodule
